// ===== rtl/cpw_pwm_top.sv
// capture/pwm block in pwm mode: period timer, prescaler, two units, apb registers
// Contract
// - period match clears timer next increment
// - period match sets pin unless duty zero
// - period match copies master into slave
// - period is (compare+1) times four prescaled clocks
// - duty is master byte plus fraction bits
// - high time is duty times prescaled clock
// - duty writes act from next period
// - slave byte read-only in pwm mode
// - pin clears when slave matches timer subcount
// - duty beyond period keeps pin high
// - zero control forces output latch low
// - postscaler does not affect period
// - prescale factors one, four, sixteen
// - code 11xx selects pwm, 0000 resets
`include "cpw_cfg.svh"
module cpw_pwm_top (
  input  wire logic        clk,       // core clock, one oscillator period
  input  wire logic        rst,       // synchronous reset, active high
  input  wire logic        psel,      // apb select
  input  wire logic        penable,   // apb access phase
  input  wire logic        pwrite,    // apb write
  input  wire logic [11:0] paddr,     // apb byte address
  input  wire logic [31:0] pwdata,    // apb write data
  input  wire logic [3:0]  pstrb,     // apb byte strobes
  output logic      [31:0] prdata,    // apb read data
  output logic             pready,    // apb ready
  output logic             pslverr,   // apb error on unmapped address
  output logic             pwmOut1,   // unit 1 pwm output pin
  output logic             pwmOut2    // unit 2 pwm output pin
);
  import cpw_pkg::*;
  logic [7:0]  periodTimerCount_q;
  logic [7:0]  periodCompareValue_q;
  logic [7:0]  periodTimerControl_q;
  logic [7:0]  unit1Master_q;
  logic [7:0]  unit1Control_q;
  logic [7:0]  unit2Master_q;
  logic [7:0]  unit2Control_q;
  logic [1:0]  qPhase_q;
  logic [3:0]  prescale_q;
  logic [7:0]  unit1Slave;
  logic [7:0]  unit2Slave;
  logic        wrEn;
  logic        rdEn;
  logic        mapped;
  logic        run;
  logic        tick;
  logic        incr;
  logic        periodMatch;
  logic [1:0]  subCount;
  logic [9:0]  timeNow;
  logic [31:0] rdata_d;

  // byte lane 0 carries every 8-bit register
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] mask);
    merge = pstrb[0] ? (pwdata[7:0] & mask) : old;
  endfunction

  // prescaler limit in quarter-phase cycles, one less than the prescale factor
  function automatic logic [3:0] psLimit(input logic [1:0] sel);
    case (sel)
      CPW_PS1: psLimit = 4'h0;
      CPW_PS4: psLimit = 4'h3;
      default: psLimit = 4'hf;
    endcase
  endfunction

  assign run     = periodTimerControl_q[`CPW_RUN_BIT];
  assign wrEn    = psel && penable && pwrite;
  assign rdEn    = psel && !pwrite;
  assign pready  = 1'b1;

  always_comb begin
    mapped = 1'b1;
    if (paddr == `CPW_OFS_TMR) begin
      rdata_d = {24'h000000, periodTimerCount_q};
    end else if (paddr == `CPW_OFS_PER) begin
      rdata_d = {24'h000000, periodCompareValue_q};
    end else if (paddr == `CPW_OFS_TCON) begin
      rdata_d = {24'h000000, periodTimerControl_q};
    end else if (paddr == `CPW_OFS_U1MST) begin
      rdata_d = {24'h000000, unit1Master_q};
    end else if (paddr == `CPW_OFS_U1SLV) begin
      rdata_d = {24'h000000, unit1Slave};
    end else if (paddr == `CPW_OFS_U1CTL) begin
      rdata_d = {24'h000000, unit1Control_q};
    end else if (paddr == `CPW_OFS_U2MST) begin
      rdata_d = {24'h000000, unit2Master_q};
    end else if (paddr == `CPW_OFS_U2SLV) begin
      rdata_d = {24'h000000, unit2Slave};
    end else if (paddr == `CPW_OFS_U2CTL) begin
      rdata_d = {24'h000000, unit2Control_q};
    end else if (paddr == `CPW_OFS_PINOUT) begin
      rdata_d = {30'h00000000, pwmOut2, pwmOut1};
    end else begin
      rdata_d = 32'h00000000;
      mapped  = 1'b0;
    end
  end

  // zero-wait slave: read data is combinational from the registers
  assign prdata  = rdEn ? rdata_d : 32'h00000000;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge clk) begin
    if (rst) begin
      periodCompareValue_q <= `CPW_RST_PER;
      periodTimerControl_q <= `CPW_RST_BYTE;
      unit1Master_q        <= `CPW_RST_BYTE;
      unit1Control_q       <= `CPW_RST_BYTE;
      unit2Master_q        <= `CPW_RST_BYTE;
      unit2Control_q       <= `CPW_RST_BYTE;
    end else if (wrEn) begin
      if (paddr == `CPW_OFS_PER) begin
        periodCompareValue_q <= merge(periodCompareValue_q, 8'hff);
      end else if (paddr == `CPW_OFS_TCON) begin
        periodTimerControl_q <= merge(periodTimerControl_q, `CPW_TCON_MASK);
      end else if (paddr == `CPW_OFS_U1MST) begin
        unit1Master_q <= merge(unit1Master_q, 8'hff);
      end else if (paddr == `CPW_OFS_U1CTL) begin
        unit1Control_q <= merge(unit1Control_q, `CPW_CTL_MASK);
      end else if (paddr == `CPW_OFS_U2MST) begin
        unit2Master_q <= merge(unit2Master_q, 8'hff);
      end else if (paddr == `CPW_OFS_U2CTL) begin
        unit2Control_q <= merge(unit2Control_q, `CPW_CTL_MASK);
      end
    end
  end

  // quarter phase: four oscillator periods per prescaled count
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      qPhase_q   <= 2'h0;
      prescale_q <= 4'h0;
    end else if (qPhase_q == `CPW_OSC_PER_TICK) begin
      qPhase_q <= 2'h0;
      if (prescale_q >= psLimit(periodTimerControl_q[`CPW_PS_HI:`CPW_PS_LO])) begin
        prescale_q <= 4'h0;
      end else begin
        prescale_q <= prescale_q + 4'h1;
      end
    end else begin
      qPhase_q <= qPhase_q + 2'h1;
    end
  end

  // sub-count runs at one oscillator period per step times the prescale factor
  always_comb begin
    case (periodTimerControl_q[`CPW_PS_HI:`CPW_PS_LO])
      CPW_PS1: begin
        subCount = qPhase_q;
        tick     = run;
      end
      CPW_PS4: begin
        subCount = prescale_q[1:0];
        tick     = run && qPhase_q == `CPW_QPH_LAST;
      end
      default: begin
        subCount = prescale_q[3:2];
        tick     = run && qPhase_q == `CPW_QPH_LAST && prescale_q[1:0] == 2'h3;
      end
    endcase
  end

  assign timeNow     = {periodTimerCount_q, subCount};
  // postscaler bits are stored but deliberately unused here
  assign incr        = run && qPhase_q == `CPW_QPH_LAST &&
                       prescale_q == psLimit(periodTimerControl_q[`CPW_PS_HI:`CPW_PS_LO]);
  assign periodMatch = incr && periodTimerCount_q == periodCompareValue_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      periodTimerCount_q <= `CPW_RST_BYTE;
    end else if (wrEn && paddr == `CPW_OFS_TMR && pstrb[0]) begin
      periodTimerCount_q <= pwdata[7:0];
    end else if (periodMatch) begin
      periodTimerCount_q <= `CPW_RST_BYTE;
    end else if (incr) begin
      periodTimerCount_q <= periodTimerCount_q + 8'h01;
    end
  end

  cpw_unit u1 (
    .clk        (clk),
    .rst        (rst),
    .ctlReg     (unit1Control_q),
    .dutyMaster (unit1Master_q),
    .periodLoad (periodMatch),
    .tick       (tick),
    .timeNow    (timeNow),
    .dutySlave  (unit1Slave),
    .pwmOut     (pwmOut1)
  );

  cpw_unit u2 (
    .clk        (clk),
    .rst        (rst),
    .ctlReg     (unit2Control_q),
    .dutyMaster (unit2Master_q),
    .periodLoad (periodMatch),
    .tick       (tick),
    .timeNow    (timeNow),
    .dutySlave  (unit2Slave),
    .pwmOut     (pwmOut2)
  );
endmodule

// ===== rtl/cpw_cfg.svh
// register offsets, field positions, reset values and timing for the pwm block
`ifndef CPW_CFG_SVH
`define CPW_CFG_SVH
`define CPW_OFS_TMR      12'h000
`define CPW_OFS_PER      12'h004
`define CPW_OFS_TCON     12'h008
`define CPW_OFS_U1MST    12'h00c
`define CPW_OFS_U1SLV    12'h010
`define CPW_OFS_U1CTL    12'h014
`define CPW_OFS_U2MST    12'h018
`define CPW_OFS_U2SLV    12'h01c
`define CPW_OFS_U2CTL    12'h020
`define CPW_OFS_PINOUT   12'h024
`define CPW_RST_PER      8'hff
`define CPW_RST_BYTE     8'h00
`define CPW_TCON_MASK    8'h7f
`define CPW_CTL_MASK     8'h3f
`define CPW_RUN_BIT      2
`define CPW_PS_LO        0
`define CPW_PS_HI        1
`define CPW_FS_LO        0
`define CPW_FS_HI        3
`define CPW_FR_LO        4
`define CPW_FR_HI        5
`define CPW_OSC_PER_TICK 2'h3
`define CPW_QPH_LAST     2'h3
`endif

// ===== rtl/cpw_pkg.sv
// types shared by the pwm block
package cpw_pkg;
  typedef enum logic [1:0] {
    CPW_PS1  = 2'h0,
    CPW_PS4  = 2'h1,
    CPW_PS16 = 2'h2
  } cpw_prescale_t;
  typedef enum logic [1:0] {
    CPW_OFF   = 2'h0,
    CPW_HIGH  = 2'h1,
    CPW_LOW   = 2'h3,
    CPW_OTHER = 2'h2
  } cpw_state_t;
endpackage

// ===== rtl/cpw_unit.sv
// one capture/pwm unit in pwm mode: duty double buffer and output latch
`include "cpw_cfg.svh"
module cpw_unit (
  input  wire logic       clk,          // core clock
  input  wire logic       rst,          // synchronous reset
  input  wire logic [7:0] ctlReg,       // unit control register
  input  wire logic [7:0] dutyMaster,   // duty master byte
  input  wire logic       periodLoad,   // period-match increment pulse
  input  wire logic       tick,         // sub-count advance
  input  wire logic [9:0] timeNow,      // timer count with sub-count
  output logic [7:0]      dutySlave,    // duty slave byte
  output logic            pwmOut        // output latch
);
  import cpw_pkg::*;
  cpw_state_t  state_q;
  logic [1:0]  latch_q;
  logic [3:0]  fsel;
  logic        pwmMode;
  logic [9:0]  nextDuty;
  logic [9:0]  timeNext;
  assign fsel     = ctlReg[`CPW_FS_HI:`CPW_FS_LO];
  assign pwmMode  = fsel[3] & fsel[2];
  assign nextDuty = {dutyMaster, ctlReg[`CPW_FR_HI:`CPW_FR_LO]};
  // compare against the step being entered so the high time is exactly duty steps long
  assign timeNext = timeNow + 10'h001;

  // slave byte and its 2-bit latch only load at the period boundary
  always_ff @(posedge clk) begin
    if (rst || fsel == 4'h0) begin
      dutySlave <= `CPW_RST_BYTE;
      latch_q   <= 2'h0;
    end else if (pwmMode && periodLoad) begin
      dutySlave <= dutyMaster;
      latch_q   <= ctlReg[`CPW_FR_HI:`CPW_FR_LO];
    end
  end

  // a duty beyond the period never matches, so the pin stays high
  always_ff @(posedge clk) begin
    if (rst || !pwmMode) begin
      state_q <= CPW_OFF;
    end else if (periodLoad) begin
      state_q <= (nextDuty == 10'h000) ? CPW_LOW : CPW_HIGH;
    end else if (tick && state_q == CPW_HIGH && {dutySlave, latch_q} == timeNext) begin
      state_q <= CPW_LOW;
    end
  end

  assign pwmOut = (state_q == CPW_HIGH);
endmodule

// ===== bench/cpw_pwm_sva.sv
// port assertions for the pwm block
`include "cpw_cfg.svh"
module cpw_pwm_sva (
  input wire logic        clk,      // clock
  input wire logic        rst,      // reset
  input wire logic        psel,     // select
  input wire logic        penable,  // access
  input wire logic        pwrite,   // write
  input wire logic [11:0] paddr,    // address
  input wire logic [31:0] pwdata,   // write data
  input wire logic [3:0]  pstrb,    // strobes
  input wire logic [31:0] prdata,   // read data
  input wire logic        pready,   // ready
  input wire logic        pslverr,  // error
  input wire logic        pwmOut1,  // pin 1
  input wire logic        pwmOut2   // pin 2
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic acc = psel && penable;
  sequence ctlZero(logic [11:0] a);
    acc && pwrite && pstrb[0] && paddr == a && pwdata[5:0] == 6'h00;
  endsequence
  sequence readOf(logic [11:0] a);
    acc && !pwrite && paddr == a;
  endsequence
  chk_ready_high: assert property (psel |-> pready) else $error("ready low");
  chk_err_unmapped: assert property (acc && paddr > `CPW_OFS_PINOUT |-> pslverr)
    else $error("unmapped not refused");
  chk_err_mapped:
    assert property (acc && paddr <= `CPW_OFS_PINOUT && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped refused");
  chk_ctl_clear1: assert property (ctlZero(`CPW_OFS_U1CTL) |=> ##1 !pwmOut1 [*3])
    else $error("pin 1 not forced low");
  chk_ctl_clear2: assert property (ctlZero(`CPW_OFS_U2CTL) |=> ##1 !pwmOut2 [*3])
    else $error("pin 2 not forced low");
  chk_ctl_upper: assert property (readOf(`CPW_OFS_U1CTL) |-> prdata[31:6] == 26'h0)
    else $error("control upper bits set");
  chk_pin_read:
    assert property (readOf(`CPW_OFS_PINOUT) |-> prdata[1:0] == {pwmOut2, pwmOut1})
    else $error("pin readback wrong");
  chk_reset_low:
    assert property (disable iff (1'b0) $fell(rst) |-> !pwmOut1 && !pwmOut2)
    else $error("pins high after reset");
endmodule
bind cpw_pwm_top cpw_pwm_sva u_sva (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pwmOut1(pwmOut1), .pwmOut2(pwmOut2));

// ===== bench/cpw_load.sv
// load on a pwm pin: measures high time and rise-to-rise period in clocks
// the pin is taken as already set to output by software
module cpw_load (
  input  wire logic clk,     // clock
  input  wire logic pin,     // pwm pin
  output int        hiLen,   // last high time
  output int        perLen   // last period
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last = 1'b0;
  int   cnt  = 0;
  int   hcnt = 0;
  always @(posedge clk) begin
    last <= pin;
    cnt  <= (pin && !last) ? 1 : cnt + 1;
    hcnt <= pin ? hcnt + 1 : 0;
    if (pin && !last) perLen <= cnt;
    if (!pin && last) hiLen <= hcnt;
  end
endmodule

// ===== bench/testbench.sv
// self-checking bench for the pwm block
`include "cpw_cfg.svh"
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin nFail++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic        pwmOut1, pwmOut2;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  int          nFail = 0, totalChecks = 0, hi1, per1, hi2, per2;
  always #2 clk = ~clk;
  cpw_pwm_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwmOut1(pwmOut1), .pwmOut2(pwmOut2));
  cpw_load ld1 (.clk(clk), .pin(pwmOut1), .hiLen(hi1), .perLen(per1));
  cpw_load ld2 (.clk(clk), .pin(pwmOut2), .hiLen(hi2), .perLen(per2));
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // answer taken at the rising edge where pready is sampled high, then released
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    int i;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      nFail++;
      tally_and_finish();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic waitPin(input logic v);
    int i;
    for (i = 0; i < 300 && pwmOut1 !== v; i++) @(negedge clk);
    if (i == 300) begin
      nFail++;
      tally_and_finish();
    end
  endtask
  task automatic t_reset;
    xfer(0, `CPW_OFS_PER, 8'h00);
    `CHK(rd[7:0], `CPW_RST_PER)
    xfer(0, `CPW_OFS_U1CTL, 8'h00);
    `CHK(rd, 32'h0)
    xfer(0, `CPW_OFS_PINOUT, 8'h00);
    `CHK(rd[1:0], 2'h0)
    xfer(0, 12'h028, 8'h00);
    `CHK(err, 1'b1)
  endtask
  task automatic t_wave(input logic [7:0] tcon, input int ps);
    xfer(1, `CPW_OFS_PER, 8'h03);
    xfer(1, `CPW_OFS_U1MST, 8'h01);
    xfer(1, `CPW_OFS_U2MST, 8'h02);
    xfer(1, `CPW_OFS_TCON, tcon);
    xfer(1, `CPW_OFS_U1CTL, 8'h2c);
    xfer(1, `CPW_OFS_U2CTL, 8'h0f);
    repeat (64 * ps) @(posedge clk);
    `CHK(per1, 16 * ps)
    `CHK(hi1, 6 * ps)
    `CHK(per2, 16 * ps)
    `CHK(hi2, 8 * ps)
  endtask
  task automatic t_hold(input logic [7:0] m, input logic lvl);
    int i;
    xfer(1, `CPW_OFS_TCON, 8'h04);
    xfer(1, `CPW_OFS_U1MST, m);
    xfer(1, `CPW_OFS_U1CTL, 8'h0c);
    repeat (40) @(posedge clk);
    for (i = 0; i < 16; i++) begin
      @(negedge clk);
      `CHK(pwmOut1, lvl)
    end
  endtask
  task automatic t_buffer;
    xfer(1, `CPW_OFS_U1MST, 8'h03);
    waitPin(1'b0);
    waitPin(1'b1);
    xfer(1, `CPW_OFS_U1SLV, 8'h55);
    xfer(1, `CPW_OFS_U1MST, 8'h01);
    xfer(0, `CPW_OFS_U1SLV, 8'h00);
    `CHK(rd[7:0], 8'h03)
    repeat (20) @(posedge clk);
    xfer(0, `CPW_OFS_U1SLV, 8'h00);
    `CHK(rd[7:0], 8'h01)
    xfer(1, `CPW_OFS_U1CTL, 8'h00);
    xfer(1, `CPW_OFS_U2CTL, 8'h00);
    repeat (2) @(negedge clk);
    `CHK({pwmOut2, pwmOut1}, 2'h0)
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_wave(8'h04, 1);
    t_wave(8'h7d, 4);
    t_wave(8'h06, 16);
    t_hold(8'h00, 1'b0);
    t_hold(8'hff, 1'b1);
    t_buffer();
    tally_and_finish();
  end
endmodule
